/* shared/hdasi_pkg.sv */
// Notes on behaviour
// - One byte per bus word, no packing
// - Transmitter sends start, data, parity, stop bits
// - Transmitter generates odd or even parity
// - Byte moving into transmitter sets buffer full
// - Finished transmit character sets buffer empty
// - Receive echo copies line input to output
// - Parity mismatch sets overrun/parity error flag
// - Receiver strips framing, presents data bits only
// - Zero data without stop bit flags break
// - Received byte stored, full/count/valid set
// - Data read sets empty, clears count
// - Unread byte overwritten sets overrun flag
// - Full, empty, break, overrun or modem status raises flag; interrupt only while control is set
// - DMA mode masks full and empty flags
// - Input with control clear returns status
// - Host configures format before any transfer
// - Mode switch keeps format; baud reloads from the mode word
// - Host drives three modem control outputs
// - Enabled modem input mismatch raises flag
// - Bit 15 resets first, then loads a configuration word; a transmit data byte in the same word is dropped
// - Baud code zero uses external x16 clock
// - DMA request when ready, unless flag pending
package hdasi_pkg;

  // 20 MHz system clock
  localparam int unsigned CLK_HZ     = 32'h0131_2D00;
  localparam int unsigned OVERSAMPLE = 32'h0000_0010;
  // Rates in tenths of a baud; entry 0 is the external clock
  localparam int unsigned BAUD_X10 [16] = '{
    1, 500, 750, 1100, 1345, 1500, 3000, 6000,
    9000, 12000, 18000, 24000, 36000, 48000, 72000, 96000};

  localparam int MR_BIT   = 15;
  localparam int TYPE_LSB = 12;
  localparam logic [2:0] WT_TXD = 3'h0;
  localparam logic [2:0] WT_ENA = 3'h1;
  localparam logic [2:0] WT_REF = 3'h2;
  localparam logic [2:0] WT_FRM = 3'h3;
  localparam logic [2:0] WT_ICT = 3'h4;
  localparam logic [2:0] WT_ISR = 3'h5;

  localparam int ST_DEV   = 15;
  localparam int ST_VALID = 14;
  localparam int ST_FULL  = 8;
  localparam int ST_EMPTY = 7;
  localparam int ST_BRK   = 6;
  localparam int ST_OVR   = 5;
  localparam int RD_VALID = 15;
  localparam int RD_COUNT = 8;
  localparam int CLR_FULL  = 3;
  localparam int CLR_EMPTY = 2;
  localparam int CLR_BRK   = 1;
  localparam int CLR_OVR   = 0;

  localparam logic [4:0] HALF_LAST = 5'h07;
  localparam logic [4:0] BIT_LAST  = 5'h0F;
  localparam logic [4:0] S15_LAST  = 5'h17;
  localparam logic [4:0] S2_LAST   = 5'h1F;
  localparam logic [3:0] MIN_BITS  = 4'h5;

  typedef struct packed {
    logic       stop2;
    logic       echo;
    logic       par_on;
    logic       par_even;
    logic [1:0] size;
  } hdasi_frame_s;

  typedef struct packed {
    logic       xmit;
    logic       ca;
    logic       cd;
    logic       sec;
    logic       dma;
    logic [3:0] baud;
  } hdasi_ictl_s;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_BIT  = 3'b010,
    TX_STOP = 3'b100
  } hdasi_tx_e;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_BIT   = 4'b0100,
    RX_STOP  = 4'b1000
  } hdasi_rx_e;

endpackage

/* core/hdasi_core.sv */
`timescale 1ns/100ps
module hdasi_core #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        out_strobe,
  input  wire logic [15:0] out_word,
  output logic             out_ready,
  input  wire logic        in_strobe,
  output logic [15:0]      in_word,
  output logic             in_valid,
  input  wire logic        ctl_set,
  input  wire logic        ctl_clear,
  output logic             flag,
  output logic             irq,
  output logic             service_request,
  input  wire logic        rxd,
  output logic             txd,
  input  wire logic        ext_clk_x16,
  input  wire logic [4:0]  modem_in,
  output logic             rts,
  output logic             dtr,
  output logic             sec_out,
  output logic             diag_out
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [2:0] wtype;
  logic       mr, wr_txd, wr_ena, wr_ref, wr_frm, wr_ict, wr_isr;
  assign wtype  = out_word[hdasi_pkg::TYPE_LSB +: 3];
  assign mr     = out_strobe & out_word[hdasi_pkg::MR_BIT];
  assign wr_txd = out_strobe & (wtype == hdasi_pkg::WT_TXD);
  assign wr_ena = out_strobe & (wtype == hdasi_pkg::WT_ENA);
  assign wr_ref = out_strobe & (wtype == hdasi_pkg::WT_REF);
  assign wr_frm = out_strobe & (wtype == hdasi_pkg::WT_FRM);
  assign wr_ict = out_strobe & (wtype == hdasi_pkg::WT_ICT);
  assign wr_isr = out_strobe & (wtype == hdasi_pkg::WT_ISR);

  // Configuration: reset by master reset, then loaded from the same word
  logic [4:0] mask_q, mask_d, ref_q, ref_d;
  logic       diag_q, diag_d, ctl_q, ctl_d;
  hdasi_pkg::hdasi_frame_s frame_q, frame_d;
  hdasi_pkg::hdasi_ictl_s  ictl_q, ictl_d;
  assign mask_d  = wr_ena ? out_word[4:0] : (mr ? '0 : mask_q);
  assign ref_d   = wr_ref ? out_word[4:0] : (mr ? '0 : ref_q);
  assign diag_d  = wr_ref ? out_word[5] : (mr ? 1'b0 : diag_q);
  assign frame_d = wr_frm ? out_word[5:0] : (mr ? '0 : frame_q);
  assign ictl_d  = wr_ict ? out_word[8:0] : (mr ? '0 : ictl_q);
  assign ctl_d   = ctl_set | (ctl_q & ~ctl_clear & ~mr);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mask_q  <= '0;
      ref_q   <= '0;
      diag_q  <= 1'b0;
      frame_q <= '0;
      ictl_q  <= '0;
      ctl_q   <= 1'b0;
    end
    else
    begin
      mask_q  <= mask_d;
      ref_q   <= ref_d;
      diag_q  <= diag_d;
      frame_q <= frame_d;
      ictl_q  <= ictl_d;
      ctl_q   <= ctl_d;
    end
  end

  assign rts      = ictl_q.ca;
  assign dtr      = ictl_q.cd;
  assign sec_out  = ictl_q.sec;
  assign diag_out = diag_q;

  // Oversampling tick, x16 the bit rate
  logic [15:0] div_tab [16];
  logic [15:0] div_q, div_d;
  logic        ext_q, ext_rise, tick;
  for (genvar g = 0; g < 16; g++)
  begin : g_div
    assign div_tab[g] = 16'(hdasi_pkg::CLK_HZ * 10 /
                       (hdasi_pkg::OVERSAMPLE * hdasi_pkg::BAUD_X10[g]));
  end
  assign ext_rise = ext_clk_x16 & ~ext_q;
  assign tick  = (ictl_q.baud == '0) ? ext_rise : (div_q == '0);
  assign div_d = (div_q == '0) ? div_tab[ictl_q.baud] - 16'h0001
                               : div_q - 16'h0001;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_q <= '0;
      ext_q <= 1'b0;
    end
    else
    begin
      div_q <= div_d;
      ext_q <= ext_clk_x16;
    end
  end

  // Frame geometry
  logic [3:0] nd, nb;
  logic [7:0] dmask;
  logic [4:0] stop_last;
  assign nd    = 4'(frame_q.size) + hdasi_pkg::MIN_BITS;
  assign nb    = nd + 4'(frame_q.par_on);
  assign dmask = 8'hFF >> (4'h8 - nd);
  assign stop_last = !frame_q.stop2 ? hdasi_pkg::BIT_LAST :
                     (frame_q.size == '0) ? hdasi_pkg::S15_LAST
                                          : hdasi_pkg::S2_LAST;

  // Two-entry transmit buffer; host is stalled by out_ready when full
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wp_q, rp_q;
  logic [CW-1:0]    cnt_q, cnt_d;
  logic             push, tx_pop, buf_full;
  assign buf_full = (cnt_q == CW'(DEPTH));
  // Words 0 in receive mode are dropped: half duplex
  assign push  = wr_txd & ictl_q.xmit & ~mr & ~buf_full;
  assign cnt_d = mr ? '0 : cnt_q + CW'(push) - CW'(tx_pop);

  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem_q[wp_q] <= out_word[WIDTH-1:0];
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_q      <= '0;
      rp_q      <= '0;
      cnt_q     <= '0;
      out_ready <= 1'b1;
    end
    else
    begin
      wp_q      <= mr ? '0 : (push ? PW'((wp_q + 1) % DEPTH) : wp_q);
      rp_q      <= mr ? '0 : (tx_pop ? PW'((rp_q + 1) % DEPTH) : rp_q);
      cnt_q     <= cnt_d;
      out_ready <= (cnt_d != CW'(DEPTH));
    end
  end

  // Transmitter
  hdasi_pkg::hdasi_tx_e tx_st_q, tx_st_d;
  logic [9:0] tx_sh_q, tx_sh_d, tx_frame;
  logic [3:0] tx_left_q, tx_left_d;
  logic [4:0] tx_sub_q, tx_sub_d;
  logic [7:0] tx_dat;
  logic       tx_par, tx_done, tx_line;
  assign tx_dat   = mem_q[rp_q] & dmask;
  assign tx_par   = ^tx_dat ^ ~frame_q.par_even;
  assign tx_frame = (10'(tx_dat) | (10'(tx_par & frame_q.par_on) << nd))
                    << 1;
  assign tx_line  = (tx_st_q != hdasi_pkg::TX_BIT) | tx_sh_q[0];

  always_comb
  begin
    tx_st_d   = tx_st_q;
    tx_sh_d   = tx_sh_q;
    tx_left_d = tx_left_q;
    tx_sub_d  = tx_sub_q;
    tx_pop    = 1'b0;
    tx_done   = 1'b0;
    unique case (tx_st_q)
      hdasi_pkg::TX_IDLE:
        if (ictl_q.xmit && cnt_q != '0 && !mr)
        begin
          tx_pop    = 1'b1;
          tx_sh_d   = tx_frame;
          tx_left_d = nb + 4'h1;
          tx_sub_d  = '0;
          tx_st_d   = hdasi_pkg::TX_BIT;
        end
      hdasi_pkg::TX_BIT:
        if (tick)
        begin
          tx_sub_d = tx_sub_q + 5'h01;
          if (tx_sub_q == hdasi_pkg::BIT_LAST)
          begin
            tx_sub_d  = '0;
            tx_sh_d   = {1'b1, tx_sh_q[9:1]};
            tx_left_d = tx_left_q - 4'h1;
            if (tx_left_q == 4'h1)
              tx_st_d = hdasi_pkg::TX_STOP;
          end
        end
      hdasi_pkg::TX_STOP:
        if (tick)
        begin
          tx_sub_d = tx_sub_q + 5'h01;
          if (tx_sub_q == stop_last)
          begin
            tx_done = 1'b1;
            tx_st_d = hdasi_pkg::TX_IDLE;
          end
        end
    endcase
    if (mr)
      tx_st_d = hdasi_pkg::TX_IDLE;
  end

  // Receiver, idle while transmitting
  hdasi_pkg::hdasi_rx_e rx_st_q, rx_st_d;
  logic [8:0] rx_sh_q, rx_sh_d, rx_bits;
  logic [3:0] rx_left_q, rx_left_d;
  logic [4:0] rx_sub_q, rx_sub_d;
  logic [7:0] rx_dat;
  logic       rx_done, par_err, break_flag;
  assign rx_bits = rx_sh_q >> (4'h9 - nb);
  assign rx_dat  = rx_bits[7:0] & dmask;
  assign par_err = frame_q.par_on &
                   (^rx_dat ^ ~frame_q.par_even ^ rx_bits[nd]);
  assign break_flag     = (rx_dat == '0) & ~rxd;

  always_comb
  begin
    rx_st_d   = rx_st_q;
    rx_sh_d   = rx_sh_q;
    rx_left_d = rx_left_q;
    rx_sub_d  = rx_sub_q;
    rx_done   = 1'b0;
    unique case (rx_st_q)
      hdasi_pkg::RX_IDLE:
        if (tick && !rxd)
        begin
          rx_sub_d = '0;
          rx_st_d  = hdasi_pkg::RX_START;
        end
      hdasi_pkg::RX_START:
        if (tick)
        begin
          rx_sub_d = rx_sub_q + 5'h01;
          if (rx_sub_q == hdasi_pkg::HALF_LAST)
          begin
            rx_sub_d  = '0;
            rx_left_d = nb;
            rx_st_d   = rxd ? hdasi_pkg::RX_IDLE : hdasi_pkg::RX_BIT;
          end
        end
      hdasi_pkg::RX_BIT:
        if (tick)
        begin
          rx_sub_d = rx_sub_q + 5'h01;
          if (rx_sub_q == hdasi_pkg::BIT_LAST)
          begin
            rx_sub_d  = '0;
            rx_sh_d   = {rxd, rx_sh_q[8:1]};
            rx_left_d = rx_left_q - 4'h1;
            if (rx_left_q == 4'h1)
              rx_st_d = hdasi_pkg::RX_STOP;
          end
        end
      hdasi_pkg::RX_STOP:
        if (tick)
        begin
          rx_sub_d = rx_sub_q + 5'h01;
          if (rx_sub_q == hdasi_pkg::BIT_LAST)
          begin
            rx_done = 1'b1;
            rx_st_d = hdasi_pkg::RX_IDLE;
          end
        end
    endcase
    if (mr || ictl_q.xmit)
    begin
      rx_st_d = hdasi_pkg::RX_IDLE;
      rx_done = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_st_q   <= hdasi_pkg::TX_IDLE;
      tx_sh_q   <= '1;
      tx_left_q <= '0;
      tx_sub_q  <= '0;
      rx_st_q   <= hdasi_pkg::RX_IDLE;
      rx_sh_q   <= '0;
      rx_left_q <= '0;
      rx_sub_q  <= '0;
      txd       <= 1'b1;
    end
    else
    begin
      tx_st_q   <= tx_st_d;
      tx_sh_q   <= tx_sh_d;
      tx_left_q <= tx_left_d;
      tx_sub_q  <= tx_sub_d;
      rx_st_q   <= rx_st_d;
      rx_sh_q   <= rx_sh_d;
      rx_left_q <= rx_left_d;
      rx_sub_q  <= rx_sub_d;
      txd <= (!ictl_q.xmit && frame_q.echo) ? rxd : tx_line;
    end
  end

  // Sticky status except dev_q, which follows modem_in; an event in the clearing cycle wins
  logic       full_q, empty_q, brk_q, ovr_q, cnt_bit_q, valid_q, dev_q;
  logic       rd_data, rd_status, flag_d;
  logic [7:0] rbuf_q;
  logic [15:0] stat_w, rdat_w;
  assign rd_data   = in_strobe & ctl_q;
  assign rd_status = in_strobe & ~ctl_q;
  assign stat_w = {dev_q, valid_q, 5'h00, full_q, empty_q, brk_q, ovr_q,
                   modem_in};
  assign rdat_w = {valid_q, 6'h00, cnt_bit_q, rbuf_q};
  assign flag_d = dev_q | brk_q | ovr_q |
                  (~ictl_q.dma & (full_q | empty_q));

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      full_q    <= 1'b0;
      empty_q   <= 1'b0;
      brk_q     <= 1'b0;
      ovr_q     <= 1'b0;
      cnt_bit_q <= 1'b0;
      valid_q   <= 1'b0;
      rbuf_q    <= '0;
      dev_q     <= 1'b0;
      flag      <= 1'b0;
      irq       <= 1'b0;
      service_request <= 1'b0;
      in_word   <= '0;
      in_valid  <= 1'b0;
    end
    else
    begin
      full_q  <= tx_pop | rx_done | (full_q & ~mr &
                 ~(wr_isr & out_word[hdasi_pkg::CLR_FULL]));
      empty_q <= tx_done | rd_data | (empty_q & ~mr &
                 ~(wr_isr & out_word[hdasi_pkg::CLR_EMPTY]));
      brk_q   <= (rx_done & break_flag) | (brk_q & ~mr &
                 ~(wr_isr & out_word[hdasi_pkg::CLR_BRK]));
      ovr_q   <= (rx_done & (par_err | (cnt_bit_q & ~rd_data))) |
                 (ovr_q & ~mr &
                 ~(wr_isr & out_word[hdasi_pkg::CLR_OVR]));
      cnt_bit_q <= rx_done | (cnt_bit_q & ~rd_data & ~mr);
      valid_q   <= rx_done | (valid_q & ~mr);
      if (rx_done)
        rbuf_q <= rx_dat;
      dev_q    <= |(mask_q & (modem_in ^ ref_q));
      flag     <= flag_d;
      irq      <= flag_d & ctl_q;
      service_request <= ictl_q.dma & ~flag_d &
                         (ictl_q.xmit ? ~buf_full : cnt_bit_q);
      if (in_strobe)
        in_word <= ctl_q ? rdat_w : stat_w;
      in_valid <= in_strobe;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_mr;
    mr && !rx_done && !ctl_set;
  endsequence
  sequence s_cleared;
    !ctl_q && !brk_q && cnt_q == '0;
  endsequence

  property p_full_on_pop;
    tx_pop |=> full_q;
  endproperty
  a_full_on_pop: assert property (p_full_on_pop)
    else $error("full not set on transmit load");

  property p_empty_on_done;
    tx_done |=> empty_q && tx_st_q == hdasi_pkg::TX_IDLE;
  endproperty
  a_empty_on_done: assert property (p_empty_on_done)
    else $error("empty not set after transmit");

  property p_echo;
    !ictl_q.xmit && frame_q.echo |=> txd == $past(rxd);
  endproperty
  a_echo: assert property (p_echo)
    else $error("echo path broken");

  property p_rx_store;
    rx_done |=> valid_q && cnt_bit_q && full_q && rbuf_q == $past(rx_dat);
  endproperty
  a_rx_store: assert property (p_rx_store)
    else $error("received byte not stored");

  property p_read;
    rd_data && !rx_done |=> empty_q && !cnt_bit_q && in_valid;
  endproperty
  a_read: assert property (p_read)
    else $error("data read effects missing");

  property p_overrun;
    rx_done && cnt_bit_q && !rd_data |=> ovr_q;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not flagged");

  property p_dma_mask;
    ictl_q.dma && !dev_q && !brk_q && !ovr_q |=> !flag;
  endproperty
  a_dma_mask: assert property (p_dma_mask)
    else $error("full or empty flagged under DMA");

  property p_status_read;
    rd_status |=> in_valid && in_word[hdasi_pkg::ST_FULL] == $past(full_q)
                  && in_word[4:0] == $past(modem_in);
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status word not returned");

  property p_mr;
    s_mr |=> s_cleared;
  endproperty
  a_mr: assert property (p_mr)
    else $error("master reset incomplete");

  property p_half;
    ictl_q.xmit |=> rx_st_q == hdasi_pkg::RX_IDLE;
  endproperty
  a_half: assert property (p_half)
    else $error("receiver active in transmit mode");

  property p_flag;
    dev_q || brk_q |=> flag;
  endproperty
  a_flag: assert property (p_flag)
    else $error("flag not raised");

endmodule

/* testbench/hdasi_term_model.sv */
`timescale 1ns/100ps
module hdasi_term_model #(
  parameter int BIT_CYC = 32
) (
  input  wire logic sys_clk,
  input  wire logic txd,
  output logic      rxd
);
  int          cap_len = 10;
  logic [11:0] frames[$];
  logic [11:0] cap;

  initial rxd = 1'b1;

  // Frame is start, data LSB first, optional parity, then one stop level
  task automatic send(input logic [7:0] d, input int n, input logic pon,
                      input logic par, input logic stop);
    logic [11:0] f;
    int          len;
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < n; i++)
      f[i + 1] = d[i];
    len = n + 1;
    if (pon)
    begin
      f[len] = par;
      len++;
    end
    f[len] = stop;
    len++;
    for (int i = 0; i < len; i++)
    begin
      @(negedge sys_clk) rxd = f[i];
      repeat (BIT_CYC - 1) @(negedge sys_clk);
    end
    // Mark level between characters, one bit time of idle
    @(negedge sys_clk) rxd = 1'b1;
    repeat (BIT_CYC) @(negedge sys_clk);
  endtask

  // Samples mid-bit; bits past cap_len are left at mark
  initial
  begin
    forever
    begin
      @(negedge txd);
      repeat (BIT_CYC / 2) @(posedge sys_clk);
      cap = '1;
      for (int i = 0; i < cap_len; i++)
      begin
        repeat (BIT_CYC) @(posedge sys_clk);
        cap[i] = txd;
      end
      frames.push_back(cap);
    end
  end
endmodule

/* testbench/hdasi_bench.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module hdasi_bench;
  localparam int BIT_CYC = 32;
  logic        sys_clk = 1'b0;
  logic        rst_n, out_strobe, out_ready, in_strobe, in_valid;
  logic [15:0] out_word, in_word, w;
  logic [11:0] exp_f;
  logic        ctl_set, ctl_clear, flag, irq, service_request;
  logic        rxd, txd, ext_clk_x16, rts, dtr, sec_out, diag_out;
  logic [4:0]  modem_in;
  logic [15:0] fw [2] = '{16'h3022, 16'h301F};
  int          num_errors = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          n;

  hdasi_core hdasi_core_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .out_strobe(out_strobe), .out_word(out_word), .out_ready(out_ready),
    .in_strobe(in_strobe), .in_word(in_word), .in_valid(in_valid),
    .ctl_set(ctl_set), .ctl_clear(ctl_clear), .flag(flag), .irq(irq),
    .service_request(service_request), .rxd(rxd), .txd(txd),
    .ext_clk_x16(ext_clk_x16), .modem_in(modem_in), .rts(rts), .dtr(dtr),
    .sec_out(sec_out), .diag_out(diag_out));

  hdasi_term_model #(.BIT_CYC(BIT_CYC)) hdasi_term_model_inst (
    .sys_clk(sys_clk), .txd(txd), .rxd(rxd));

  always #25 sys_clk = ~sys_clk;
  // Baud code zero: one x16 tick every two system clocks
  always @(negedge sys_clk) ext_clk_x16 <= ~ext_clk_x16;

  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end

  task automatic wr(input logic [15:0] d);
    @(negedge sys_clk) out_word = d;
    out_strobe = 1'b1;
    @(negedge sys_clk) out_strobe = 1'b0;
  endtask

  task automatic rd(input logic set, output logic [15:0] d);
    @(negedge sys_clk) ctl_set = set;
    ctl_clear = ~set;
    @(negedge sys_clk) ctl_set = 1'b0;
    ctl_clear = 1'b0;
    in_strobe = 1'b1;
    @(negedge sys_clk) in_strobe = 1'b0;
    `CHK(in_valid, 1'b1)
    d = in_word;
  endtask

  task automatic wait_frames(input int k);
    int i;
    i = 0;
    while (hdasi_term_model_inst.frames.size() < k && i < 5000)
    begin
      @(posedge sys_clk);
      i++;
    end
  endtask

  function automatic logic [11:0] frm(input logic [7:0] d, input int nb,
                                      input logic pon, input logic ev);
    logic [11:0] f;
    logic [7:0]  m;
    m = d & ~(8'hFF << nb);
    f = '1;
    for (int i = 0; i < nb; i++)
      f[i] = m[i];
    if (pon)
      f[nb] = ev ? ^m : ~^m;
    return f;
  endfunction

  initial
  begin
    {out_strobe, in_strobe, ctl_set, ctl_clear, ext_clk_x16} = '0;
    out_word = 16'h0000;
    modem_in = 5'h00;
    rst_n = 1'b0;
    repeat (12) @(negedge sys_clk);
    rst_n = 1'b1;
    `CHK({txd, out_ready}, 2'b11)
    rd(1'b0, w); `CHK(w, 16'h0000)
    wr(16'h41E0);
    wr(16'h2020);
    `CHK({rts, dtr, sec_out, diag_out}, 4'hF)
    for (int f = 0; f < 2; f++)
    begin
      n = int'(fw[f][1:0]) + 5;
      wr(fw[f]);
      wr(16'h500F);
      hdasi_term_model_inst.cap_len = n + int'(fw[f][3]) + 1 + int'(fw[f][5]);
      hdasi_term_model_inst.frames.delete();
      // Fourth word meets a full two-entry buffer and is dropped
      for (int k = 0; k < 4; k++)
        wr({8'h00, 8'hA5 + 8'(k * 17)});
      `CHK(out_ready, 1'b0)
      rd(1'b0, w); `CHK(w & 16'h0100, 16'h0100)
      wait_frames(3);
      repeat (4 * BIT_CYC) @(negedge sys_clk);
      `CHK(hdasi_term_model_inst.frames.size(), 3)
      for (int k = 0; k < 3; k++)
      begin
        exp_f = frm(8'hA5 + 8'(k * 17), n, fw[f][3], fw[f][2]);
        `CHK(hdasi_term_model_inst.frames[k], exp_f)
      end
      rd(1'b0, w); `CHK(w & 16'h0080, 16'h0080)
      `CHK(flag, 1'b1)
    end
    // Format kept from the last transmit pass: 8 bits, even, echo
    wr(16'h4000);
    wr(16'h500F);
    hdasi_term_model_inst.cap_len = 10;
    hdasi_term_model_inst.frames.delete();
    hdasi_term_model_inst.send(8'h5A, 8, 1'b1, ^8'h5A, 1'b1);
    wait_frames(1);
    exp_f = frm(8'h5A, 8, 1'b1, 1'b1);
    `CHK(hdasi_term_model_inst.frames[0], exp_f)
    rd(1'b0, w); `CHK(w & 16'h4160, 16'h4100)
    rd(1'b1, w); `CHK(w, 16'h815A)
    rd(1'b1, w); `CHK(w, 16'h805A)
    rd(1'b0, w); `CHK(w & 16'h0080, 16'h0080)
    wr(16'h500F);
    hdasi_term_model_inst.send(8'h5A, 8, 1'b1, ~^8'h5A, 1'b1);
    rd(1'b0, w); `CHK(w & 16'h0020, 16'h0020)
    rd(1'b1, w);
    wr(16'h500F);
    hdasi_term_model_inst.send(8'h00, 8, 1'b1, 1'b0, 1'b0);
    rd(1'b0, w); `CHK(w & 16'h0060, 16'h0040)
    rd(1'b1, w);
    wr(16'h500F);
    hdasi_term_model_inst.send(8'h11, 8, 1'b1, ^8'h11, 1'b1);
    hdasi_term_model_inst.send(8'h22, 8, 1'b1, ^8'h22, 1'b1);
    rd(1'b0, w); `CHK(w & 16'h0020, 16'h0020)
    rd(1'b1, w);
    hdasi_term_model_inst.frames.delete();
    wr(16'h0033);
    repeat (12 * BIT_CYC) @(negedge sys_clk);
    `CHK(hdasi_term_model_inst.frames.size(), 0)
    wr(16'h4110);
    wr(16'h500F);
    repeat (2) @(negedge sys_clk);
    `CHK({flag, service_request}, 2'b01)
    wr(16'h0077);
    repeat (12 * BIT_CYC) @(negedge sys_clk);
    // A byte kept from receive mode would show up here as the first frame
    `CHK(hdasi_term_model_inst.frames.size(), 1)
    exp_f = frm(8'h77, 8, 1'b1, 1'b1);
    `CHK(hdasi_term_model_inst.frames[0], exp_f)
    `CHK(flag, 1'b0)
    rd(1'b0, w); `CHK(w & 16'h0180, 16'h0180)
    wr(16'h1001);
    wr(16'h2000);
    @(negedge sys_clk) modem_in = 5'h01;
    repeat (3) @(negedge sys_clk);
    `CHK({flag, service_request}, 2'b10)
    rd(1'b0, w); `CHK(w & 16'h801F, 16'h8001)
    rd(1'b1, w); `CHK(irq, 1'b1)
    wr(16'hC080);
    repeat (2) @(negedge sys_clk);
    `CHK({rts, dtr, sec_out, irq}, 4'b1000)
    rd(1'b0, w); `CHK(w, 16'h0001)
    tally_and_finish();
  end
endmodule
